// ### cpls_pkg.sv
package cpls_pkg;

    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned BE_W       = 4;

    localparam logic [3:0]  OFS_ALU_STATUS_WORD    = 4'h0;
    localparam logic [3:0]  OFS_CPU_CORE_CONTROL   = 4'h4;
    localparam logic [3:0]  OFS_FIRST_INT_CONTROL  = 4'h8;

    localparam int unsigned FIELD_LSB  = 5;
    localparam int unsigned FIELD_MSB  = 7;
    localparam int unsigned EXT_POS    = 3;
    localparam int unsigned NEST_POS   = 15;
    localparam int unsigned FIELD_BE   = 0;
    localparam int unsigned EXT_BE     = 0;
    localparam int unsigned NEST_BE    = 1;

    localparam logic [2:0]  FIELD_RST  = 3'h0;
    localparam logic        EXT_RST    = 1'b0;
    localparam logic        NEST_RST   = 1'b0;
    localparam logic [2:0]  FIELD_TOP  = 3'h7;
    localparam logic [3:0]  LEVEL_BASE_MAX = 4'h7;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    typedef struct packed {
        logic       ext;
        logic [2:0] field;
    } cpls_level_s;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0]   byteenable;
        logic [DATA_W-1:0] writedata;
    } cpls_req_s;

endpackage

// ### cpls_core.sv
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Priority level field sits in status word bits 7:5, codes 0..7.
// - Field at 111 blocks every user interrupt source.
// - Extension bit 3 of core control sits above the field, giving levels 8..15.
// - While nesting disable is 1, software writes to the field are ignored.
// - Unimplemented bits of all three registers read zero and ignore writes.
// - Extension bit set only for levels above 7; software may clear, never set it.
module cpls_core
    import cpls_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [BE_W-1:0]   avs_byteenable,
    input  wire logic [DATA_W-1:0] avs_writedata,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              level_load,
    input  wire logic [3:0]        level_load_val,
    output cpls_level_s            cpu_level,
    output logic                   user_irq_block
);

    cpls_req_s   req;
    cpls_level_s level_r;
    cpls_level_s level_nxt;
    logic        nest_dis_r;
    logic        wait_r;
    logic [DATA_W-1:0] rdata_r;
    logic        block_r;
    logic        wr_go;
    logic        wr_sr;
    logic        wr_cc;
    logic        wr_ic;

    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr,
        input cpls_level_s       lvl,
        input logic              nest
    );
        logic [DATA_W-1:0] d;
        d = '0;
        unique case (addr)
            OFS_ALU_STATUS_WORD:   d[FIELD_MSB:FIELD_LSB] = lvl.field;
            OFS_CPU_CORE_CONTROL:  d[EXT_POS]  = lvl.ext;
            OFS_FIRST_INT_CONTROL: d[NEST_POS] = nest;
            default:               d = '0;
        endcase
        return d;
    endfunction

    assign req.read       = avs_read;
    assign req.write      = avs_write;
    assign req.address    = avs_address;
    assign req.byteenable = avs_byteenable;
    assign req.writedata  = avs_writedata;

    // The access completes at the edge where waitrequest is low; one wait cycle
    // keeps read data registered without a combinational path to the bus.
    assign wr_go = req.write && !wait_r;
    assign wr_sr = wr_go && (req.address == OFS_ALU_STATUS_WORD) && req.byteenable[FIELD_BE];
    assign wr_cc = wr_go && (req.address == OFS_CPU_CORE_CONTROL) && req.byteenable[EXT_BE];
    assign wr_ic = wr_go && (req.address == OFS_FIRST_INT_CONTROL) && req.byteenable[NEST_BE];

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_r <= 1'b1;
        end
        else if ((req.read || req.write) && wait_r)
        begin
            wait_r <= 1'b0;
        end
        else
        begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_r <= RDATA_RST;
        end
        else if (req.read && wait_r)
        begin
            rdata_r <= read_mux(req.address, level_r, nest_dis_r);
        end
    end

    // A level loaded by the core on exception entry or return wins over a
    // software write in the same cycle, since the core must never lose a level.
    always_comb
    begin
        level_nxt = level_r;
        if (level_load)
        begin
            level_nxt.field = level_load_val[2:0];
            level_nxt.ext   = (level_load_val > LEVEL_BASE_MAX);
        end
        else
        begin
            if (wr_sr && !nest_dis_r)
            begin
                level_nxt.field = req.writedata[FIELD_MSB:FIELD_LSB];
            end
            if (wr_cc && !req.writedata[EXT_POS])
            begin
                level_nxt.ext = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            level_r.field <= FIELD_RST;
            level_r.ext   <= EXT_RST;
        end
        else
        begin
            level_r <= level_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nest_dis_r <= NEST_RST;
        end
        else if (wr_ic)
        begin
            nest_dis_r <= req.writedata[NEST_POS];
        end
    end

    // Levels 8 and up also shut out user sources, which can only reach 7.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            block_r <= 1'b0;
        end
        else
        begin
            block_r <= (level_nxt.field == FIELD_TOP) || level_nxt.ext;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign cpu_level       = level_r;
    assign user_irq_block  = block_r;

endmodule

`default_nettype wire

// ### cpls_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cpls_core_chk
    import cpls_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        level_load,
    input wire logic [3:0]  level_load_val,
    input wire cpls_level_s cpu_level,
    input wire logic        user_irq_block
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_LOAD: assert property (level_load |=> cpu_level == $past(level_load_val))
        else $error("level not loaded");
    AST_EXT: assert property ($rose(cpu_level.ext) |-> $past(level_load))
        else $error("extension set without load");
    AST_STILL: assert property (!level_load && !avs_write |=> $stable(cpu_level))
        else $error("level moved with no cause");
    AST_BLK: assert property (user_irq_block == (&cpu_level.field || cpu_level.ext))
        else $error("block flag wrong");
    AST_ZERO: assert property (!avs_waitrequest |-> (avs_readdata & 32'hFFFF7F17) == 32'h0)
        else $error("unimplemented bits set");
    AST_RST: assert property ($rose(rst_b) |-> cpu_level == 4'h0 && !user_irq_block)
        else $error("reset level wrong");
    AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer late");
    cover property (level_load && level_load_val == 4'hF);
    cover property (avs_write && !avs_waitrequest);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind cpls_core cpls_core_chk u_chk (.*);
`default_nettype wire

// ### cpls_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpls_core_tb
    import cpls_pkg::*;
;
    logic mclk = 0, rst_b = 0, avs_read = 0, avs_write = 0, level_load = 0;
    logic [3:0] avs_address = 0, avs_byteenable = 0, level_load_val = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic avs_waitrequest, user_irq_block;
    cpls_level_s cpu_level;
    int err_count = 0, n_compared = 0;
    cpls_core dut (
        .mclk            (mclk),
        .rst_b           (rst_b),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_byteenable  (avs_byteenable),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .level_load      (level_load),
        .level_load_val  (level_load_val),
        .cpu_level       (cpu_level),
        .user_irq_block  (user_irq_block)
    );
    initial forever #25 mclk = ~mclk;
    task automatic close_out;
        $display("errors %0d checks %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Holds the request until waitrequest is seen low, then idles one edge.
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 4'hF);
        chk(q, e);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b1, 4'h0, 32'hFFFFFF1F | (32'(i) << 5), 4'hF);
            rd(4'h0, 32'(i) << 5);
            chk({31'h0, user_irq_block}, {31'h0, i == 7});
        end
        acc(1'b1, 4'h4, 32'hFFFFFFFF, 4'hF);
        rd(4'h4, 32'h0);
        level_load <= 1'b1;
        level_load_val <= 4'hF;
        @(posedge mclk);
        level_load <= 1'b0;
        rd(4'h4, 32'h8);
        rd(4'h0, 32'hE0);
        acc(1'b1, 4'h4, 32'h0, 4'h1);
        rd(4'h4, 32'h0);
        acc(1'b1, 4'h8, 32'h8000, 4'h2);
        acc(1'b1, 4'h0, 32'h20, 4'h1);
        rd(4'h0, 32'hE0);
        rd(4'h8, 32'h8000);
        acc(1'b1, 4'h8, 32'h0, 4'h2);
        acc(1'b1, 4'h0, 32'h20, 4'h1);
        rd(4'h0, 32'h20);
        acc(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
        rd(4'hC, 32'h0);
        level_load <= 1'b1;
        level_load_val <= 4'hF;
        @(posedge mclk);
        level_load <= 1'b0;
        @(posedge mclk);
        chk({31'h0, user_irq_block}, 32'h1);
        chk({28'h0, cpu_level}, 32'hF);
        level_load <= 1'b1;
        level_load_val <= 4'h5;
        @(posedge mclk);
        level_load <= 1'b0;
        @(posedge mclk);
        chk({31'h0, user_irq_block}, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h0, 32'hA0);
        rst_b <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        chk({28'h0, cpu_level}, 32'h0);
        close_out();
    end
    initial
    begin
        #100us;
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
